// [logic/tpo_top.sv]
module tpo_top
    import tpo_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              pce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Timer compare matches, one per channel
    input  wire logic [NCH-1:0]    cmp_a,
    input  wire logic [NCH-1:0]    cmp_b,
    // Pattern pins
    output logic      [NPIN-1:0]   pattern_out_pins,
    output logic      [NPIN-1:0]   pattern_out_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [SEL_W-1:0] grp_sel(input logic [REG_W-1:0] trig,
                                                 input int g);
        grp_sel = trig[g*SEL_W +: SEL_W];
    endfunction : grp_sel

    function automatic logic same_trig(input logic [REG_W-1:0] trig, input int g);
        same_trig = (grp_sel(trig, g) == grp_sel(trig, g + 1));
    endfunction : same_trig

    logic [REG_W-1:0] mode_q, mode_d;
    logic [REG_W-1:0] trig_q, trig_d;
    logic [REG_W-1:0] nde_up_q, nde_up_d;
    logic [REG_W-1:0] nde_lo_q, nde_lo_d;
    logic [REG_W-1:0] ndv_up_q, ndv_up_d;
    logic [REG_W-1:0] ndv_lo_q, ndv_lo_d;
    logic [REG_W-1:0] dir_a_q, dir_a_d;
    logic [REG_W-1:0] val_a_q, val_a_d;
    logic [REG_W-1:0] dir_b_q, dir_b_d;
    logic [REG_W-1:0] val_b_q, val_b_d;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic              pready_q, pready_d;
    logic              pslverr_q, pslverr_d;

    logic [15:0]       idx;
    logic              wr_en;
    logic [REG_W-1:0]  wb;
    logic              same01;
    logic              same23;
    logic [NPIN-1:0]   nde_all;
    logic [NPIN-1:0]   ndv_all;
    logic [NPIN-1:0]   ld;
    logic [REG_W-1:0]  rd_val;
    logic              rd_hit;

    assign idx    = paddr[ADDR_W-1:IDX_LSB];
    assign wr_en  = psel & penable & pwrite & pready_q & pstrb[0];
    assign wb     = pwdata[REG_W-1:0];
    assign same01 = same_trig(trig_q, 0);
    assign same23 = same_trig(trig_q, 2);
    assign nde_all = {nde_up_q[GRP_W-1:0], nde_lo_q};
    assign ndv_all = {ndv_up_q[GRP_W-1:0], ndv_lo_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Per-group trigger units; group 3 has no pins and no transfer

    for (genvar g = 0; g < NGRP; g++) begin : g_grp                 // RL1
        tpo_group u_grp (
            .sel    (grp_sel(trig_q, g)),
            .nonovl (mode_q[g]),
            .nde    (nde_all[g*GRP_W +: GRP_W]),
            .ndv    (ndv_all[g*GRP_W +: GRP_W]),
            .cmp_a  (cmp_a),
            .cmp_b  (cmp_b),
            .load   (ld[g*GRP_W +: GRP_W])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rd_hit = 1'b1;
        unique case (idx)
            IDX_MODE:       rd_val = mode_q;
            IDX_TRIG:       rd_val = trig_q;
            IDX_NDE_UP:     rd_val = nde_up_q;
            IDX_NDE_LO:     rd_val = nde_lo_q;
            IDX_NDV_LO:     rd_val = same01 ? ndv_lo_q : {ndv_lo_q[7:4], NIB_ONES}; // RL7
            IDX_NDV_LO_ALT: rd_val = same01 ? RSVD_READ : {NIB_ONES, ndv_lo_q[3:0]}; // RL14
            IDX_NDV_UP:     rd_val = same23 ? ndv_up_q : {ndv_up_q[7:4], NIB_ONES}; // RL9
            IDX_NDV_UP_ALT: rd_val = same23 ? RSVD_READ : {NIB_ONES, ndv_up_q[3:0]};
            IDX_DIR_A:      rd_val = DIR_READ;
            IDX_DIR_B:      rd_val = DIR_READ;
            IDX_VAL_A:      rd_val = val_a_q;
            IDX_VAL_B:      rd_val = val_b_q;
            default: begin
                rd_val = RST_ZERO;
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: answer in the first access cycle

    always_comb begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            pready_d  = 1'b1;
            pslverr_d = !rd_hit;
            prdata_d  = {{(DATA_W-REG_W){1'b0}}, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and pattern transfer

    always_comb begin
        mode_d   = mode_q;
        trig_d   = trig_q;
        nde_up_d = nde_up_q;
        nde_lo_d = nde_lo_q;
        ndv_up_d = ndv_up_q;
        ndv_lo_d = ndv_lo_q;
        dir_a_d  = dir_a_q;
        dir_b_d  = dir_b_q;
        val_a_d  = (val_a_q & ~ld[7:0]) | (ndv_lo_q & ld[7:0]);     // RL12
        val_b_d  = {val_b_q[7:4],
                    (val_b_q[3:0] & ~ld[11:8]) | (ndv_up_q[3:0] & ld[11:8])}; // RL10
        if (wr_en) begin
            unique case (idx)
                IDX_MODE:   mode_d   = {MODE_HI, wb[3:0]};
                IDX_TRIG:   trig_d   = wb;
                IDX_NDE_UP: nde_up_d = wb;
                IDX_NDE_LO: nde_lo_d = wb;                          // RL2
                IDX_NDV_LO: begin
                    if (same01) begin
                        ndv_lo_d = wb;                              // RL7
                    end else begin
                        ndv_lo_d[7:4] = wb[7:4];                    // RL8
                    end
                end
                IDX_NDV_LO_ALT: begin
                    if (!same01) begin
                        ndv_lo_d[3:0] = wb[3:0];                    // RL8
                    end
                end
                IDX_NDV_UP: begin
                    if (same23) begin
                        ndv_up_d = wb;                              // RL9
                    end else begin
                        ndv_up_d[7:4] = wb[7:4];
                    end
                end
                IDX_NDV_UP_ALT: begin
                    if (!same23) begin
                        ndv_up_d[3:0] = wb[3:0];                    // RL9
                    end
                end
                IDX_DIR_A:  dir_a_d = wb;
                IDX_DIR_B:  dir_b_d = wb;
                IDX_VAL_A:  val_a_d = (val_a_d & nde_lo_q) | (wb & ~nde_lo_q); // RL6
                IDX_VAL_B:  val_b_d = (val_b_d & nde_up_q) | (wb & ~nde_up_q); // RL6
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= RST_MODE;                                  // RL11
            trig_q    <= RST_TRIG;
            nde_up_q  <= RST_ZERO;
            nde_lo_q  <= RST_ZERO;
            ndv_up_q  <= RST_ZERO;
            ndv_lo_q  <= RST_ZERO;
            dir_a_q   <= RST_ZERO;
            val_a_q   <= RST_ZERO;
            dir_b_q   <= RST_ZERO;
            val_b_q   <= RST_ZERO;
            prdata_q  <= RD_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (pce) begin
            mode_q    <= mode_d;
            trig_q    <= trig_d;
            nde_up_q  <= nde_up_d;
            nde_lo_q  <= nde_lo_d;
            ndv_up_q  <= ndv_up_d;
            ndv_lo_q  <= ndv_lo_d;
            dir_a_q   <= dir_a_d;
            val_a_q   <= val_a_d;
            dir_b_q   <= dir_b_d;
            val_b_q   <= val_b_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    // Pins 0-7 from port A, 8-11 from the low nibble of port B
    assign pattern_out_pins = {val_b_q[3:0], val_a_q};              // RL5
    assign pattern_out_oe   = {dir_b_q[3:0], dir_a_q};              // RL13

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_trigger_load: assert property (pce && ld != '0 |=>               // RL12
        (pattern_out_pins & $past(ld)) == ($past({ndv_up_q[3:0], ndv_lo_q}) & $past(ld)))
        else $error("triggered bits did not take next data");
    a_disabled_hold: assert property (pce && !(wr_en && idx == IDX_VAL_A) |=> // RL15
        ((val_a_q ^ $past(val_a_q)) & ~$past(nde_lo_q)) == '0)
        else $error("non-enabled port bit changed without a write");
    a_write_protect: assert property (pce && wr_en && idx == IDX_VAL_A && ld[7:0] == '0 |=> // RL6
        (val_a_q & $past(nde_lo_q)) == ($past(val_a_q) & $past(nde_lo_q)))
        else $error("write reached a pattern-owned port bit");
    a_reserved_read: assert property (pce && psel && !penable && same01 // RL14
        && idx == IDX_NDV_LO_ALT |=> prdata_q[7:0] == RSVD_READ && pready_q)
        else $error("reserved next-data address did not read all ones");
    a_shared_write: assert property (pce && wr_en && idx == IDX_NDV_LO && same01 // RL7
        |=> ndv_lo_q == $past(wb))
        else $error("shared next-data write not stored whole");
    a_split_write: assert property (pce && wr_en && idx == IDX_NDV_LO_ALT && !same01 // RL8
        |=> ndv_lo_q[3:0] == $past(wb[3:0]) && ndv_lo_q[7:4] == $past(ndv_lo_q[7:4]))
        else $error("group 0 next data not stored at its own address");
    a_upper_split: assert property (pce && wr_en && idx == IDX_NDV_UP_ALT && !same23 // RL9
        |=> ndv_up_q[3:0] == $past(wb[3:0]) && ndv_up_q[7:4] == $past(ndv_up_q[7:4]))
        else $error("group 2 next data not stored at its own address");
    a_no_group3: assert property (pce && !(wr_en && idx == IDX_VAL_B) |=> // RL10
        val_b_q[7:4] == $past(val_b_q[7:4]))
        else $error("group 3 port bits changed by a trigger");
    a_mode_fixed: assert property (mode_q[7:4] == MODE_HI)                // RL11
        else $error("fixed mode bits lost their value");
    a_nonoverlap: assert property (pce && mode_q[0] && nde_lo_q[0]    // RL4
        && cmp_a[trig_q[1:0]] && !cmp_b[trig_q[1:0]]
        && !(wr_en && idx == IDX_VAL_A) |=> !(val_a_q[0] && !$past(val_a_q[0])))
        else $error("pin rose on a falling-edge match in non-overlap mode");

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer, register storage and transfer checks

    a_ready_pulse: assert property (pce && psel && !penable
        |=> pready_q && prdata_q[REG_W-1:0] == $past(rd_val))
        else $error("setup cycle not answered with the addressed register");
    a_unmapped_err: assert property (pce && psel && !penable && !rd_hit
        |=> pslverr_q && prdata_q == RD_ZERO)
        else $error("unmapped index not refused");
    a_mapped_ok: assert property (pce && psel && !penable && rd_hit
        |=> !pslverr_q)
        else $error("mapped index flagged as an error");
    a_enable_store: assert property (pce && wr_en && idx == IDX_NDE_LO // RL2
        |=> nde_lo_q == $past(wb))
        else $error("next-enable write not stored");
    a_trig_store: assert property (pce && wr_en && idx == IDX_TRIG // RL3
        |=> trig_q == $past(wb))
        else $error("trigger select write not stored");
    a_free_bits: assert property (pce && wr_en && idx == IDX_VAL_A // RL6
        |=> (val_a_q & ~$past(nde_lo_q)) == ($past(wb) & ~$past(nde_lo_q)))
        else $error("non-pattern port bit ignored a write");
    a_port_protect: assert property (pce && wr_en && idx == IDX_VAL_B // RL6
        && ld[11:8] == '0 |=> (val_b_q & $past(nde_up_q)) == ($past(val_b_q) & $past(nde_up_q)))
        else $error("write reached a pattern-owned port B bit");
    a_reserved_hold: assert property (pce && wr_en && idx == IDX_NDV_LO_ALT && same01 // RL14
        |=> ndv_lo_q == $past(ndv_lo_q))
        else $error("reserved next-data address accepted a write");
    a_group_hold: assert property (pce && ld[3:0] == '0 && !(wr_en && idx == IDX_VAL_A) // RL1
        |=> val_a_q[3:0] == $past(val_a_q[3:0]))
        else $error("group 0 port bits moved without their own trigger");
    a_upper_shared: assert property (pce && wr_en && idx == IDX_NDV_UP && same23 // RL9
        |=> ndv_up_q == $past(wb))
        else $error("shared upper next-data write not stored whole");
    a_group1_split: assert property (pce && wr_en && idx == IDX_NDV_LO && !same01 // RL8
        |=> ndv_lo_q[7:4] == $past(wb[7:4]) && ndv_lo_q[3:0] == $past(ndv_lo_q[3:0]))
        else $error("group 1 next data not stored alone");
    a_rise_on_b: assert property (pce && mode_q[0] && nde_lo_q[0] && ndv_lo_q[0] // RL4
        && cmp_b[trig_q[1:0]] && !cmp_a[trig_q[1:0]] |=> val_a_q[0])
        else $error("rising bit did not follow match B in non-overlap mode");

    c_trigger: cover property (pce && ld[3:0] != '0 ##1 pattern_out_pins[3:0] != '0);
    c_reserved: cover property (pce && psel && !penable && idx == IDX_NDV_LO_ALT && same01);
    c_nonovl: cover property (pce && mode_q[0] && ld[3:0] != '0);
    c_split: cover property (pce && !same01 && ld[7:4] != '0);
    c_refused: cover property (pce && pslverr_q);

endmodule : tpo_top

// [logic/tpo_pkg.sv]
// Notes on behaviour
// RL1: Pattern outputs form three independent 4-bit groups, numbered 0 to 2.
// RL2: Twelve pattern output bits at most, each enabled on its own.
// RL3: Each group picks its trigger from compare matches of four timer channels.
// RL4: Non-overlap mode separates falling and rising output changes by a margin.
// RL5: Pins 0-3 are group 0, 4-7 group 1, 8-11 group 2; outputs only.
// RL6: Port value bits used for pattern output ignore writes but stay readable.
// RL7: Groups 0 and 1 sharing a trigger use one full byte at ffa5.
// RL8: Different triggers: group 0 next data at ffa7, group 1 at ffa5.
// RL9: Groups 2/3 shared trigger use ffa4; different triggers put group 2 at ffa6.
// RL10: Group 3 has no pins; it lives only in the upper next-value nibble.
// RL11: Reset gives mode f0, trigger select ff, every other register zero.
// RL12: A selected compare match copies the group's next data into port value.
// RL13: Software sets the direction bit of every pin used for pattern output.
// RL14: With a shared 0/1 trigger, ffa7 is reserved: unwritable, reads all ones.
// RL15: Only bits with next-enable set take new data on a trigger.
package tpo_pkg;

    localparam int          ADDR_W    = 18;
    localparam int          IDX_LSB   = 2;
    localparam int          DATA_W    = 32;
    localparam int          REG_W     = 8;
    localparam int          GRP_W     = 4;
    localparam int          NGRP      = 3;
    localparam int          NPIN      = NGRP * GRP_W;
    localparam int          NCH       = 4;
    localparam int          SEL_W     = 2;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE      = 16'hffa0;
    localparam logic [15:0] IDX_TRIG      = 16'hffa1;
    localparam logic [15:0] IDX_NDE_UP    = 16'hffa2;
    localparam logic [15:0] IDX_NDE_LO    = 16'hffa3;
    localparam logic [15:0] IDX_NDV_UP    = 16'hffa4;
    localparam logic [15:0] IDX_NDV_LO    = 16'hffa5;
    localparam logic [15:0] IDX_NDV_UP_ALT = 16'hffa6;
    localparam logic [15:0] IDX_NDV_LO_ALT = 16'hffa7;
    localparam logic [15:0] IDX_DIR_A     = 16'hffd1;
    localparam logic [15:0] IDX_VAL_A     = 16'hffd3;
    localparam logic [15:0] IDX_DIR_B     = 16'hffd4;
    localparam logic [15:0] IDX_VAL_B     = 16'hffd6;

    localparam logic [7:0]  RST_MODE  = 8'hf0;
    localparam logic [7:0]  RST_TRIG  = 8'hff;
    localparam logic [7:0]  RST_ZERO  = 8'h00;
    localparam logic [7:0]  RSVD_READ = 8'hff;
    localparam logic [7:0]  DIR_READ  = 8'h00;
    localparam logic [3:0]  MODE_HI   = 4'hf;
    localparam logic [3:0]  NIB_ONES  = 4'hf;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

endpackage : tpo_pkg

// [logic/tpo_group.sv]
module tpo_group
    import tpo_pkg::*;
(
    // Configuration
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic             nonovl,
    input  wire logic [GRP_W-1:0] nde,
    input  wire logic [GRP_W-1:0] ndv,
    // Timer compare matches
    input  wire logic [NCH-1:0]   cmp_a,
    input  wire logic [NCH-1:0]   cmp_b,
    // Transfer request
    output logic      [GRP_W-1:0] load
);

    logic hit_a;
    logic hit_b;

    always_comb begin
        hit_a = cmp_a[sel];                                         // RL3
        hit_b = cmp_b[sel];
        if (nonovl) begin
            // Falling bits move at match A, rising bits later at match B
            load = nde & (({GRP_W{hit_a}} & ~ndv) | ({GRP_W{hit_b}} & ndv)); // RL4
        end else begin
            load = nde & {GRP_W{hit_a}};                            // RL15
        end
    end

endmodule : tpo_group

// [bench/tpo_load.sv]
module tpo_load (
    // Pins from the block
    input  wire logic [11:0] pins,
    input  wire logic [11:0] oe,
    // Level that the loads see
    output logic      [11:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Undriven pins fall to the pull-down level
    always_comb begin
        seen = pins & oe;
    end

endmodule : tpo_load

// [bench/tb_top.sv]
module tb_top
    import tpo_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic              pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0]        pstrb, cmp_a, cmp_b;
    logic [NPIN-1:0]   pins, oe, seen;
    logic [7:0]        pa, pb, nl, nu, el, eu, w, r;
    logic [15:0]       zi [8] = '{IDX_NDE_UP, IDX_NDE_LO, IDX_NDV_UP, IDX_NDV_LO,
                                  IDX_VAL_A, IDX_VAL_B, IDX_DIR_A, IDX_DIR_B};
    int                err_count, num_checks;

    tpo_top i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_a(cmp_a), .cmp_b(cmp_b), .pattern_out_pins(pins), .pattern_out_oe(oe));
    tpo_load i_load (.pins(pins), .oe(oe), .seen(seen));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt(input logic [7:0] o, e, v);
        return (o & ~e) | (v & e);
    endfunction : nxt

    function automatic logic [7:0] wprot(input logic [7:0] o, e, d);
        return (o & e) | (d & ~e);
    endfunction : wprot

    task automatic chk(input string nm, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       input logic [3:0] st);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr8(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'hf);
    endtask : wr8

    task automatic chkrd(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 4'hf);
        chk(nm, {24'h0, exp}, rd);
    endtask : chkrd

    task automatic pulse(input logic [3:0] a, b);
        cmp_a <= a;
        cmp_b <= b;
        @(posedge pclk);
        cmp_a <= 4'h0;
        cmp_b <= 4'h0;
        @(posedge pclk);
        @(posedge pclk);
    endtask : pulse

    task automatic chkpins(input logic [11:0] exp);
        #1;
        chk("pins", {20'h0, exp}, {20'h0, seen});
        chk("oe", 32'h0000_0fff, {20'h0, oe});
        @(posedge pclk);
    endtask : chkpins

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_count++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, cmp_a, cmp_b, pa, pb} = '0;
        {pce, pstrb, paddr, pwdata} = {1'b1, 4'hf, 50'h0};
        void'($urandom(32'h2606));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pins_rst", 32'h0, {8'h0, pins, oe});
        chkrd("mode_rst", IDX_MODE, RST_MODE);
        chkrd("trig_rst", IDX_TRIG, RST_TRIG);
        foreach (zi[i]) chkrd("zero_rst", zi[i], RST_ZERO);
        apb(1'b0, 16'h1234, 8'h00, 4'hf);
        chk("pslverr", 32'h1, {31'h0, er});
        apb(1'b1, IDX_MODE, 8'h0f, 4'h0);
        chkrd("mode_nostrb", IDX_MODE, RST_MODE);
        wr8(IDX_DIR_A, 8'hff);
        wr8(IDX_DIR_B, 8'h0f);
        // Shared trigger on channel 3, random enables and data
        repeat (6) begin
            {el, eu, nl, nu, w} = 40'({$urandom, $urandom});
            wr8(IDX_NDE_LO, el);
            wr8(IDX_NDE_UP, eu);
            wr8(IDX_NDV_LO, nl);
            wr8(IDX_NDV_UP, nu);
            chkrd("ndv_lo", IDX_NDV_LO, nl);
            chkrd("ndv_up", IDX_NDV_UP, nu);
            wr8(IDX_NDV_LO_ALT, w);
            chkrd("rsvd", IDX_NDV_LO_ALT, RSVD_READ);
            wr8(IDX_VAL_A, w);
            wr8(IDX_VAL_B, ~w);
            pa = wprot(pa, el, w);
            pb = wprot(pb, eu, ~w);
            chkrd("val_a", IDX_VAL_A, pa);
            chkrd("val_b", IDX_VAL_B, pb);
            pulse(4'h8, 4'h0);
            pa = nxt(pa, el, nl);
            pb = nxt(pb, eu & 8'h0f, nu);
            chkpins({pb[3:0], pa});
            chkrd("val_b_trig", IDX_VAL_B, pb);
        end
        // Each group on its own channel
        wr8(IDX_TRIG, 8'he4);
        wr8(IDX_NDE_LO, 8'hff);
        wr8(IDX_NDE_UP, 8'h0f);
        {nl, nu} = 16'($urandom);
        wr8(IDX_NDV_LO_ALT, nl);
        wr8(IDX_NDV_LO, nl);
        wr8(IDX_NDV_UP_ALT, nu);
        chkrd("ndv_g0", IDX_NDV_LO_ALT, {4'hf, nl[3:0]});
        chkrd("ndv_g1", IDX_NDV_LO, {nl[7:4], 4'hf});
        for (int g = 0; g < 3; g++) begin
            pulse(4'h1 << g, 4'h0);
            if (g == 0) pa[3:0] = nl[3:0];
            else if (g == 1) pa[7:4] = nl[7:4];
            else pb[3:0] = nu[3:0];
            chkpins({pb[3:0], pa});
        end
        // Non-overlap on group 0: zeros on match A, ones on match B
        wr8(IDX_NDE_LO, 8'h00);
        r = 8'($urandom);
        pa[3:0] = ~r[3:0];
        wr8(IDX_VAL_A, pa);
        wr8(IDX_NDE_LO, 8'h0f);
        wr8(IDX_NDV_LO_ALT, r);
        wr8(IDX_MODE, 8'h01);
        chkrd("mode_rw", IDX_MODE, 8'hf1);
        pulse(4'h1, 4'h0);
        pa[3:0] = pa[3:0] & r[3:0];
        chkpins({pb[3:0], pa});
        pulse(4'h0, 4'h1);
        pa[3:0] = r[3:0];
        chkpins({pb[3:0], pa});
        results();
    end

endmodule : tb_top
